// ---- dv/spm_far_end.sv ----
`default_nettype none
module spm_far_end (
   input wire logic pclk,
   input wire logic shift_clk,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] m0_byte = 8'h00;
   int m0_idx = 9;
   initial line = 1'b1;
   // load the byte for the next mode-0 receive
   task automatic arm_m0(input logic [7:0] d);
      m0_byte = d;
      m0_idx = 0;
   endtask
   // next bit on each shift clock fall, lsb first
   always @(negedge shift_clk) begin
      if (m0_idx < 8) begin
         line <= m0_byte[m0_idx];
         m0_idx <= m0_idx + 1;
      end
   end
   // after the last rise the data is no longer held
   always @(posedge shift_clk) begin
      if (m0_idx == 8) begin
         line <= ~line;
         m0_idx <= 9;
      end
   end
   // async frame lsb first, per cycles a bit, then idle high
   task automatic send_async(input logic [10:0] b, input int n, input int per);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge pclk);
         line <= b[i];
         repeat (per - 1) @(posedge pclk);
      end
      @(posedge pclk);
      line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- dv/spm_serial_port_sva.sv ----
`default_nettype none
module spm_serial_port_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_ovf,
   input wire logic rxd_in,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   input wire logic txd
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] falls;
   // shift clock falls seen while mode-0 transmit drives the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         falls <= 4'h0;
      end else if (!rxd_oe) begin
         falls <= 4'h0;
      end else if ($fell(txd)) begin
         falls <= falls + 4'h1;
      end
   end
   a_ready_one_wait: assert property ($rose(psel && penable) |=> pready)
      else $error("pready not in second access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_refused_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access without zero data");
   a_oe_clock_runs: assert property ($rose(rxd_oe) |-> ##[1:12] !txd)
      else $error("no shift clock after transmit start");
   a_low_span: assert property ($fell(txd) && rxd_oe |->
      (!txd [*2] ##1 txd) or (!txd [*6] ##1 txd))
      else $error("shift clock low time wrong");
   a_high_span: assert property ($rose(txd) && rxd_oe |->
      (txd [*2] ##1 !txd) or (txd [*6] ##1 !txd) or (##[1:8] !rxd_oe))
      else $error("shift clock period wrong");
   a_data_lead: assert property ($changed(rxd_out) && rxd_oe && txd |->
      (##1 !txd) or (txd [*3] ##1 !txd))
      else $error("data lead before clock fall wrong");
   a_eight_falls: assert property ($fell(rxd_oe) |-> falls == 4'h8)
      else $error("mode-0 frame without eight shift clocks");
endmodule
bind spm_serial_port spm_serial_port_sva #(.ADDR_W(ADDR_W)) i_spm_serial_port_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf),
   .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd)
);
`default_nettype wire

// ---- dv/tb.sv ----
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   failures++; $display("ERROR %0t: got %0h expected %0h", $time, g, e); \
   end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rxd_in, rxd_out, rxd_oe, txd, far_line;
   logic timer_ovf = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   spm_serial_port #(.ADDR_W(12)) i_spm_serial_port (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf),
      .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
   spm_far_end i_spm_far_end (.pclk(pclk), .shift_clk(txd), .line(far_line));
   // wire level of the shared data pin
   assign rxd_in = rxd_oe ? rxd_out : far_line;
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // timer overflow every second cycle, and the hang limit
   always @(posedge pclk) begin
      timer_ovf <= ~timer_ovf;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one apb transfer: setup, access, hold until pready
   task automatic apb(input logic wr_en, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] r, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK(n < 20, 1'b1)
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 8'h00, r, e);
   endtask
   task automatic poll(input int b, output logic [31:0] v);
      int n;
      n = 0;
      do begin
         rd(spm_pkg::ADDR_CTRL, v);
         n++;
      end while (v[b] !== 1'b1 && n < 200);
   endtask
   function automatic logic [7:0] ctl(input logic [1:0] m, input logic en,
      input logic mp, input logic t8);
      return {m, mp, en, t8, 3'b000};
   endfunction
   // capture an async frame from txd at mid bit
   task automatic cap(input int nb, input int per, output logic [10:0] f,
      output int w);
      int i;
      f = '1;
      w = 0;
      while (txd !== 1'b0 && w < 2000) begin
         @(posedge pclk);
         w++;
      end
      repeat (per / 2) @(posedge pclk);
      for (i = 0; i < nb; i++) begin
         f[i] = txd;
         if (i < nb - 1) repeat (per) @(posedge pclk);
      end
   endtask
   // mode-0 transmit: bits at clock rises, low time and period
   task automatic m0_tx(input logic sel, input logic [7:0] d);
      logic [7:0] got;
      logic [31:0] v;
      logic pv;
      int nb, lo, tf, n;
      got = 8'h00;
      pv = 1'b1;
      nb = 0;
      lo = 0;
      tf = -1;
      wr(spm_pkg::ADDR_BUF, d);
      for (n = 0; n < 300 && nb < 8; n++) begin
         @(posedge pclk);
         if (rxd_oe === 1'b1 && txd === 1'b0) lo++;
         if (pv === 1'b0 && txd === 1'b1 && rxd_oe === 1'b1) begin
            got = {rxd_out, got[7:1]};
            nb++;
         end
         if (pv === 1'b1 && txd === 1'b0) begin
            if (tf >= 0) `CHK(n - tf, sel ? 4 : 12)
            tf = n;
         end
         pv = txd;
      end
      `CHK(got, d)
      `CHK(lo, sel ? 16 : 48)
      repeat (12) @(posedge pclk);
      rd(spm_pkg::ADDR_CTRL, v);
      `CHK(v[1], 1'b1)
   endtask
   initial begin
      logic [31:0] v;
      logic e;
      logic [10:0] f;
      logic [7:0] d;
      int w, k;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then an unmapped address is refused
      rd(spm_pkg::ADDR_CTRL, v); `CHK(v, 32'h0)
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'h0)
      rd(spm_pkg::ADDR_PWR, v); `CHK(v, 32'h0)
      apb(1'b1, 12'h00C, 8'hFF, v, e); `CHK(e, 1'b1)
      apb(1'b0, 12'h00C, 8'h00, v, e); `CHK({e, v}, 33'h100000000)
      // mode-0 transmit at both rates
      for (k = 0; k < 2; k++) begin
         wr(spm_pkg::ADDR_CTRL, ctl(spm_pkg::MODE0, 1'b0, k[0], 1'b0));
         m0_tx(k[0], 8'hA6 ^ 8'(k));
      end
      // mode-0 receive, then the shift clock stays quiet
      i_spm_far_end.arm_m0(8'h3B);
      wr(spm_pkg::ADDR_CTRL, ctl(spm_pkg::MODE0, 1'b1, 1'b0, 1'b0));
      poll(0, v); `CHK(v[0], 1'b1)
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'h3B)
      k = 0;
      repeat (60) begin
         @(posedge pclk);
         if (txd !== 1'b1) k++;
      end
      `CHK(k, 0)
      // full duplex in mode 1, a frame each way at once
      i_spm_far_end.send_async(11'h7FF, 1, 4);
      wr(spm_pkg::ADDR_PWR, 8'h01);
      wr(spm_pkg::ADDR_CTRL, ctl(spm_pkg::MODE1, 1'b1, 1'b0, 1'b0));
      `CHK(txd, 1'b1)
      fork
         i_spm_far_end.send_async({2'b11, 8'h3C, 1'b0}, 10, 32);
         begin
            wr(spm_pkg::ADDR_BUF, 8'h96);
            cap(10, 32, f, w);
         end
      join
      `CHK(f, {2'b11, 8'h96, 1'b0})
      `CHK(w <= 34, 1'b1)
      rd(spm_pkg::ADDR_CTRL, v); `CHK(v[2:0], 3'b111)
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'h3C)
      // frame lost while rx done is still set
      i_spm_far_end.send_async({2'b11, 8'h11, 1'b0}, 10, 32);
      repeat (40) @(posedge pclk);
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'h3C)
      // select bit set: a frame with stop 0 is lost
      wr(spm_pkg::ADDR_CTRL, ctl(spm_pkg::MODE1, 1'b1, 1'b1, 1'b0));
      i_spm_far_end.send_async({2'b10, 8'h22, 1'b0}, 10, 32);
      repeat (40) @(posedge pclk);
      rd(spm_pkg::ADDR_CTRL, v); `CHK(v[0], 1'b0)
      // short start pulse dropped, next frame taken
      i_spm_far_end.send_async(11'h000, 1, 6);
      repeat (40) @(posedge pclk);
      i_spm_far_end.send_async({2'b11, 8'h44, 1'b0}, 10, 32);
      poll(0, v); `CHK(v[0], 1'b1)
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'h44)
      // transmit in modes 1, 2, 2 and 3 at both rates
      for (k = 0; k < 4; k++) begin
         d = 8'h5D + 8'(k);
         wr(spm_pkg::ADDR_PWR, {7'h0, k[0]});
         wr(spm_pkg::ADDR_CTRL, ctl(k == 0 ? spm_pkg::MODE1 : k < 3 ?
            spm_pkg::MODE2 : spm_pkg::MODE3, 1'b0, 1'b0, k[0]));
         wr(spm_pkg::ADDR_BUF, d);
         cap(k == 0 ? 10 : 11, k[0] ? 32 : 64, f, w);
         `CHK(f, k == 0 ? {2'b11, d, 1'b0} : {1'b1, k[0], d, 1'b0})
         rd(spm_pkg::ADDR_CTRL, v); `CHK(v[1], 1'b1)
      end
      // mode-2 receive: ninth bit in its own field
      wr(spm_pkg::ADDR_CTRL, ctl(spm_pkg::MODE2, 1'b1, 1'b0, 1'b0));
      i_spm_far_end.send_async({1'b1, 1'b0, 8'hE7, 1'b0}, 11, 32);
      poll(0, v); `CHK(v[2:0], 3'b001)
      rd(spm_pkg::ADDR_BUF, v); `CHK(v, 32'hE7)
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- hw/spm_baud_tick.sv ----
`default_nettype none
module spm_baud_tick (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] mode,
   input wire logic baud_double,
   input wire logic timer_ovf,
   output logic tick
);
   logic [1:0] osc_cnt;
   logic ovf_half;
   logic [1:0] osc_last;

   assign osc_last = baud_double ? spm_pkg::M2_TICK_DIV_FAST :
                     spm_pkg::M2_TICK_DIV_SLOW;

   // oscillator divider for mode 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt <= 2'h0;
      end else if (osc_cnt >= osc_last) begin
         osc_cnt <= 2'h0;
      end else begin
         osc_cnt <= osc_cnt + 2'h1;
      end
   end

   // halves the timer overflow when not doubled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_half <= 1'b0;
      end else if (timer_ovf) begin
         ovf_half <= ~ovf_half;
      end
   end

   // 16x sample tick; mode 3 runs from the timer like mode 1
   always_comb begin
      if (mode == spm_pkg::MODE2) begin
         tick = (osc_cnt >= osc_last); // see (RULE21)
      end else if (mode == spm_pkg::MODE0) begin
         tick = 1'b0;
      end else begin
         tick = timer_ovf & (baud_double | ovf_half); // see (RULE12) (RULE23)
      end
   end
endmodule
`default_nettype wire

// ---- hw/spm_pkg.sv ----
`default_nettype none
package spm_pkg;
   // register byte addresses on the bus
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_BUF = 12'h004;
   localparam logic [11:0] ADDR_PWR = 12'h008;
   // serial_control_reg field positions
   localparam int CTRL_RX_DONE = 0;
   localparam int CTRL_TX_DONE = 1;
   localparam int CTRL_RX_NINTH = 2;
   localparam int CTRL_TX_NINTH = 3;
   localparam int CTRL_RX_EN = 4;
   localparam int CTRL_RATE_MP = 5;
   localparam int CTRL_MODE_LO = 6;
   // power_control_reg field position
   localparam int PWR_BAUD_DOUBLE = 0;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   // serial modes
   localparam logic [1:0] MODE0 = 2'h0;
   localparam logic [1:0] MODE1 = 2'h1;
   localparam logic [1:0] MODE2 = 2'h2;
   localparam logic [1:0] MODE3 = 2'h3;
   // mode-0 bit timing in pclk cycles
   localparam logic [3:0] M0_SLOW_PERIOD = 4'hC;
   localparam logic [3:0] M0_SLOW_LEAD = 4'h3;
   localparam logic [3:0] M0_SLOW_LOW = 4'h6;
   localparam logic [3:0] M0_FAST_PERIOD = 4'h4;
   localparam logic [3:0] M0_FAST_LEAD = 4'h1;
   localparam logic [3:0] M0_FAST_LOW = 4'h2;
   localparam logic [3:0] M0_LAST_BIT = 4'h7;
   // oscillator divide to the 16x tick in mode 2
   localparam logic [1:0] M2_TICK_DIV_FAST = 2'h1;
   localparam logic [1:0] M2_TICK_DIV_SLOW = 2'h3;
   // divide-by-16 counter states
   localparam logic [3:0] DIV16_LAST = 4'hF;
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_SECOND = 4'h8;
   localparam logic [3:0] VOTE_THIRD = 4'h9;
   // async frame lengths after the start bit
   localparam logic [3:0] M1_BITS_AFTER_START = 4'h9;
   localparam logic [3:0] M2_BITS_AFTER_START = 4'hA;
   localparam logic [3:0] NINTH_INDEX = 4'h9;
endpackage
`default_nettype wire

// ---- hw/spm_serial_port.sv ----
// Behaviour
// (RULE1) buffer write loads transmitter; buffer read returns receive buffer
// (RULE2) async modes transmit and receive independently at once
// (RULE3) mode 0: data both ways on rxd, shift clock driven on txd
// (RULE4) mode 0: eight bits per frame, least significant first
// (RULE5) mode 0 rate: osc/12 with select clear, osc/4 with it set
// (RULE6) fast mode 0: data 1 clock before fall, clock low 2
// (RULE7) slow mode 0: data 3 clocks before fall, clock low 6
// (RULE8) mode 0 write shifts out eight bits, then sets tx done
// (RULE9) mode 0 receive runs while enabled and rx done clear
// (RULE10) far device changes data on the shift clock falling edge
// (RULE11) mode 1 frame: start 0, eight data, stop 1 into ninth field
// (RULE12) mode 1 rate: timer overflow over 16 or 32
// (RULE13) async bits go out on divide-by-16 rollovers after write
// (RULE14) mode 1 tx done set at tenth rollover with stop bit
// (RULE15) receive samples at 16x; falling edge resets the counter
// (RULE16) bit value is majority of states 8, 9 and 10; the code votes at divide-by-16 counter states 7, 8 and 9
// (RULE17) start bit read as 1 aborts and rearms edge detect
// (RULE18) load buffer only if rx done clear and select 0 or stop 1
// (RULE19) after mid stop bit receiver looks for a new falling edge
// (RULE20) mode 2 frame: start, eight data, ninth bit, stop
// (RULE21) mode 2 rate: osc over 32 or 64 by baud double bit
// (RULE22) mode 2 tx done set at eleventh rollover with stop bit
// (RULE23) mode 3 is mode 2 timed from the timer overflow
// (RULE24) async transmit line idles high
// (RULE25) mode 2 stop bit is driven high
`default_nettype none
module spm_serial_port #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_ovf,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd
);
   typedef enum logic [1:0] {SPM_M0_IDLE, SPM_M0_TX, SPM_M0_RX} spm_m0_t;
   typedef enum logic {SPM_RX_IDLE, SPM_RX_BUSY} spm_rx_t;

   // register state
   logic [1:0] mode;
   logic rate_mp;
   logic rx_en;
   logic tx_ninth;
   logic rx_ninth;
   logic tx_done;
   logic rx_done;
   logic baud_double;
   logic [7:0] rx_buf;

   // bus decode
   logic access;
   logic wr_en;
   logic wr_ctrl;
   logic wr_buf;
   logic wr_pwr;
   logic [7:0] ctrl_view;

   // pin synchroniser
   logic rxd_s1;
   logic rxd_s2;
   logic rxd_s3;
   logic rxd_f;

   // mode 0 engine
   spm_m0_t m0_state;
   logic [3:0] m0_phase;
   logic [3:0] m0_cnt;
   logic [7:0] m0_sh;
   logic [3:0] m0_period;
   logic [3:0] m0_lead;
   logic [3:0] m0_rise;
   logic m0_end;
   logic m0_rx_load;
   logic m0_tx_fin;
   logic sclk;

   // async engines
   logic tick;
   logic [3:0] tx_div;
   logic tx_roll;
   logic tx_pend;
   logic [10:0] tx_sh;
   logic [3:0] tx_left;
   logic txd_a;
   logic tx_fin;
   spm_rx_t rx_state;
   logic [3:0] rx_div;
   logic [3:0] rx_bit;
   logic [7:0] rx_data;
   logic rx_b9;
   logic [1:0] rx_votes;
   logic rx_prev;
   logic rx_val;
   logic [3:0] rx_last;
   logic a_rx_end;
   logic a_rx_load;

   function automatic logic spm_major(input logic a, input logic b,
                                      input logic c);
      spm_major = (a & b) | (a & c) | (b & c);
   endfunction

   function automatic logic spm_hit(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] reg_addr);
      spm_hit = (a == ADDR_W'(reg_addr));
   endfunction

   // bus decode; one wait state on every access
   assign access = psel & penable;
   assign wr_en = access & pready & pwrite;
   assign wr_ctrl = wr_en & spm_hit(paddr, spm_pkg::ADDR_CTRL);
   assign wr_buf = wr_en & spm_hit(paddr, spm_pkg::ADDR_BUF);
   assign wr_pwr = wr_en & spm_hit(paddr, spm_pkg::ADDR_PWR);
   assign ctrl_view = {mode, rate_mp, rx_en, tx_ninth, rx_ninth,
                       tx_done, rx_done};

   // answer and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (access & ~pready) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (spm_hit(paddr, spm_pkg::ADDR_CTRL)) begin
            prdata[7:0] <= ctrl_view;
         end else if (spm_hit(paddr, spm_pkg::ADDR_BUF)) begin
            prdata[7:0] <= rx_buf; // see (RULE1)
         end else if (spm_hit(paddr, spm_pkg::ADDR_PWR)) begin
            prdata[spm_pkg::PWR_BAUD_DOUBLE] <= baud_double;
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // software control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_MODE_LO+:2];
         rate_mp <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_RATE_MP];
         rx_en <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_RX_EN];
         tx_ninth <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_TX_NINTH];
         baud_double <= spm_pkg::PWR_RESET[spm_pkg::PWR_BAUD_DOUBLE];
      end else begin
         if (wr_ctrl) begin
            mode <= pwdata[spm_pkg::CTRL_MODE_LO+:2];
            rate_mp <= pwdata[spm_pkg::CTRL_RATE_MP];
            rx_en <= pwdata[spm_pkg::CTRL_RX_EN];
            tx_ninth <= pwdata[spm_pkg::CTRL_TX_NINTH];
         end
         if (wr_pwr) begin
            baud_double <= pwdata[spm_pkg::PWR_BAUD_DOUBLE];
         end
      end
   end

   // transmit done flag; a hardware set beats a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_done <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_TX_DONE];
      end else if (m0_tx_fin | tx_fin) begin
         tx_done <= 1'b1; // see (RULE8) (RULE14) (RULE22)
      end else if (wr_ctrl) begin
         tx_done <= pwdata[spm_pkg::CTRL_TX_DONE];
      end
   end

   // receive buffer, ninth field and done flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_done <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_RX_DONE];
         rx_ninth <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_RX_NINTH];
         rx_buf <= spm_pkg::BUF_RESET;
      end else if (m0_rx_load) begin
         rx_done <= 1'b1; // see (RULE9)
         rx_buf <= {rxd_f, m0_sh[7:1]};
      end else if (a_rx_load) begin
         rx_done <= 1'b1; // see (RULE18)
         rx_buf <= rx_data;
         rx_ninth <= (mode == spm_pkg::MODE1) ? rx_val : rx_b9; // see (RULE11) (RULE20)
      end else if (wr_ctrl) begin
         rx_done <= pwdata[spm_pkg::CTRL_RX_DONE];
         rx_ninth <= pwdata[spm_pkg::CTRL_RX_NINTH];
      end
   end

   // receive pin: change accepted once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         rxd_s3 <= 1'b1;
         rxd_f <= 1'b1;
      end else begin
         rxd_s1 <= rxd_in;
         rxd_s2 <= rxd_s1;
         rxd_s3 <= rxd_s2;
         if (rxd_s2 == rxd_s3) begin
            rxd_f <= rxd_s3;
         end
      end
   end

   // mode 0 bit timing from the rate select bit
   assign m0_period = rate_mp ? spm_pkg::M0_FAST_PERIOD :
                      spm_pkg::M0_SLOW_PERIOD; // see (RULE5)
   assign m0_lead = rate_mp ? spm_pkg::M0_FAST_LEAD :
                    spm_pkg::M0_SLOW_LEAD; // see (RULE6) (RULE7)
   assign m0_rise = m0_lead + (rate_mp ? spm_pkg::M0_FAST_LOW :
                    spm_pkg::M0_SLOW_LOW); // see (RULE6) (RULE7)
   assign m0_end = (m0_phase == m0_period - 4'h1);
   assign sclk = (m0_state == SPM_M0_IDLE) |
                 (m0_phase < m0_lead) | (m0_phase >= m0_rise);
   assign m0_tx_fin = (m0_state == SPM_M0_TX) & m0_end &
                      (m0_cnt == spm_pkg::M0_LAST_BIT);
   // far end changes data at the fall, so it is stable at the rise
   assign m0_rx_load = (m0_state == SPM_M0_RX) & (m0_phase == m0_rise) &
                       (m0_cnt == spm_pkg::M0_LAST_BIT); // see (RULE10)

   // mode 0 synchronous half-duplex shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_state <= SPM_M0_IDLE;
         m0_phase <= 4'h0;
         m0_cnt <= 4'h0;
         m0_sh <= 8'h00;
      end else begin
         case (m0_state)
            SPM_M0_IDLE: begin
               m0_phase <= 4'h0;
               m0_cnt <= 4'h0;
               if (mode == spm_pkg::MODE0 && wr_buf) begin
                  m0_sh <= pwdata[7:0]; // see (RULE1) (RULE8)
                  m0_state <= SPM_M0_TX;
               end else if (mode == spm_pkg::MODE0 && rx_en && !rx_done) begin
                  m0_state <= SPM_M0_RX; // see (RULE9)
               end
            end
            SPM_M0_TX: begin
               if (m0_end) begin
                  m0_phase <= 4'h0;
                  m0_sh <= {1'b0, m0_sh[7:1]}; // see (RULE4)
                  m0_cnt <= m0_cnt + 4'h1;
                  if (m0_cnt == spm_pkg::M0_LAST_BIT) begin
                     m0_state <= SPM_M0_IDLE;
                  end
               end else begin
                  m0_phase <= m0_phase + 4'h1;
               end
            end
            SPM_M0_RX: begin
               if (m0_phase == m0_rise) begin
                  m0_sh <= {rxd_f, m0_sh[7:1]}; // see (RULE4) (RULE9)
               end
               if (m0_rx_load) begin
                  m0_state <= SPM_M0_IDLE;
               end else if (m0_end) begin
                  m0_phase <= 4'h0;
                  m0_cnt <= m0_cnt + 4'h1;
               end else begin
                  m0_phase <= m0_phase + 4'h1;
               end
            end
            default: begin
               m0_state <= SPM_M0_IDLE;
            end
         endcase
      end
   end

   // 16x tick source for the async modes
   spm_baud_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .mode(mode),
      .baud_double(baud_double),
      .timer_ovf(timer_ovf),
      .tick(tick)
   );

   // transmit divide-by-16 counter runs free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div <= 4'h0;
      end else if (tick) begin
         tx_div <= tx_div + 4'h1;
      end
   end
   assign tx_roll = tick & (tx_div == spm_pkg::DIV16_LAST);
   assign tx_fin = tx_roll & (tx_left == 4'h1);

   // async transmitter, bits launched only on rollovers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pend <= 1'b0;
         tx_sh <= 11'h7FF;
         tx_left <= 4'h0;
         txd_a <= 1'b1;
      end else begin
         if (wr_buf && mode != spm_pkg::MODE0 && tx_left == 4'h0) begin
            tx_pend <= 1'b1; // see (RULE1)
            // stop bit high in every async mode
            tx_sh <= {1'b1, (mode == spm_pkg::MODE1) ? 1'b1 : tx_ninth,
                      pwdata[7:0], 1'b0}; // see (RULE11) (RULE20) (RULE25)
         end else if (tx_roll && tx_left != 4'h0) begin
            txd_a <= tx_sh[0]; // see (RULE13)
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_left <= tx_left - 4'h1;
         end else if (tx_roll && tx_pend) begin
            txd_a <= tx_sh[0]; // see (RULE13)
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_pend <= 1'b0;
            tx_left <= (mode == spm_pkg::MODE1) ?
                       spm_pkg::M1_BITS_AFTER_START :
                       spm_pkg::M2_BITS_AFTER_START; // see (RULE14) (RULE22)
         end
      end
   end

   // async receiver
   assign rx_last = (mode == spm_pkg::MODE1) ? spm_pkg::M1_BITS_AFTER_START :
                    spm_pkg::M2_BITS_AFTER_START;
   assign rx_val = spm_major(rx_votes[0], rx_votes[1], rxd_f); // see (RULE16)
   assign a_rx_end = (rx_state == SPM_RX_BUSY) & tick &
                     (rx_div == spm_pkg::VOTE_THIRD) & (rx_bit == rx_last);
   assign a_rx_load = a_rx_end & ~rx_done & (~rate_mp | rx_val); // see (RULE18)

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= SPM_RX_IDLE;
         rx_div <= 4'h0;
         rx_bit <= 4'h0;
         rx_data <= 8'h00;
         rx_b9 <= 1'b0;
         rx_votes <= 2'h0;
         rx_prev <= 1'b1;
      end else if (tick) begin
         rx_prev <= rxd_f; // see (RULE15)
         case (rx_state)
            SPM_RX_IDLE: begin
               if (rx_en && rx_prev && !rxd_f) begin
                  rx_state <= SPM_RX_BUSY; // see (RULE2)
                  rx_div <= 4'h0; // see (RULE15)
                  rx_bit <= 4'h0;
               end
            end
            SPM_RX_BUSY: begin
               rx_div <= rx_div + 4'h1;
               if (rx_div == spm_pkg::VOTE_FIRST) begin
                  rx_votes[0] <= rxd_f; // see (RULE16)
               end
               if (rx_div == spm_pkg::VOTE_SECOND) begin
                  rx_votes[1] <= rxd_f; // see (RULE16)
               end
               if (rx_div == spm_pkg::VOTE_THIRD) begin
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == 4'h0 && rx_val) begin
                     rx_state <= SPM_RX_IDLE; // see (RULE17)
                  end else if (rx_bit == rx_last) begin
                     rx_state <= SPM_RX_IDLE; // see (RULE19)
                  end else if (rx_bit == spm_pkg::NINTH_INDEX) begin
                     rx_b9 <= rx_val; // see (RULE20)
                  end else if (rx_bit != 4'h0) begin
                     rx_data <= {rx_val, rx_data[7:1]}; // see (RULE11)
                  end
               end
            end
            default: begin
               rx_state <= SPM_RX_IDLE;
            end
         endcase
      end
   end

   // pins: mode 0 uses txd as the shift clock
   assign txd = (mode == spm_pkg::MODE0) ? sclk : txd_a; // see (RULE3) (RULE24)
   assign rxd_out = m0_sh[0]; // see (RULE3)
   assign rxd_oe = (m0_state == SPM_M0_TX); // see (RULE3)
endmodule
`default_nettype wire
